// >>> hw/umlps_regs.svh
// register map, bit positions and reset values of the modem-line block
`ifndef UMLPS_REGS_SVH
`define UMLPS_REGS_SVH

// register byte offsets on the bus
`define UMLPS_P1_STAT_OFS    8'h00
`define UMLPS_P1_CTL_OFS     8'h04
`define UMLPS_P1_IER_OFS     8'h08
`define UMLPS_P2_STAT_OFS    8'h0c
`define UMLPS_P2_CTL_OFS     8'h10
`define UMLPS_P2_IER_OFS     8'h14
`define UMLPS_SBCFG_OFS      8'h18
`define UMLPS_GP4_CTL_OFS    8'h1c
`define UMLPS_GP4_IN_OFS     8'h20
`define UMLPS_ADDR_W         8

// synchroniser lanes: per port cts, dsr, ri, dcd, then rxd2 and dtr1
`define UMLPS_SYNC_W         10
`define UMLPS_P1_LO          0
`define UMLPS_P2_LO          4
`define UMLPS_RXD2           8
`define UMLPS_DTR1_IN        9

// modem control register fields
`define UMLPS_CTL_DTR        0
`define UMLPS_CTL_RTS        1
`define UMLPS_CTL_LOOP       4
`define UMLPS_CTL_W          5
// interrupt enable: modem-status enable bit
`define UMLPS_IER_MSI        3
`define UMLPS_IER_W          4
// chipset configuration: pin-for-timer select
`define UMLPS_CHIP_PWM       2
`define UMLPS_CHIP_W         8

// general-purpose port four bit numbers of the first port's pins
`define UMLPS_GP_DCD         0
`define UMLPS_GP_RI          3
`define UMLPS_GP_DTR         5
`define UMLPS_GP_DSR         6
`define UMLPS_GP_CTS         7
`define UMLPS_GP_W           8
// control word: select [7:0], direction [15:8], output data [23:16]
`define UMLPS_GP_SEL_LO      0
`define UMLPS_GP_DIR_LO      8
`define UMLPS_GP_OUT_LO      16

// reset values
`define UMLPS_RST_CTL        5'h00
`define UMLPS_RST_IER        4'h0
`define UMLPS_RST_CHIP       8'h00
`define UMLPS_RST_GP         8'h00
`define UMLPS_RST_SYNC       10'h3ff

// bus encodings
`define UMLPS_HTRANS_NSEQ    1'b1
`define UMLPS_HSIZE_WORD     3'h2

`endif

// >>> hw/umlps_pkg.sv
// types shared by the modem-line block
`default_nettype none
`include "umlps_regs.svh"
package umlps_pkg;
	typedef enum logic [1:0] {
		UMLPS_BUS_IDLE  = 2'b00,
		UMLPS_BUS_WRITE = 2'b01,
		UMLPS_BUS_READ  = 2'b10
	} umlps_bus_e;

	typedef struct packed {
		logic [`UMLPS_SYNC_W-1:0] s1;
		logic [`UMLPS_SYNC_W-1:0] s2;
		logic [`UMLPS_SYNC_W-1:0] s3;
		logic [3:0]               dlt1;
		logic [3:0]               dlt2;
		logic                     chg1;
		logic                     chg2;
		logic [`UMLPS_CTL_W-1:0]  ctl1;
		logic [`UMLPS_CTL_W-1:0]  ctl2;
		logic [`UMLPS_IER_W-1:0]  ier1;
		logic [`UMLPS_IER_W-1:0]  ier2;
		logic [`UMLPS_CHIP_W-1:0] sbcfg;
		logic [`UMLPS_GP_W-1:0]   gp_sel;
		logic [`UMLPS_GP_W-1:0]   gp_dir;
		logic [`UMLPS_GP_W-1:0]   gp_out;
		umlps_bus_e               bus;
		logic [`UMLPS_ADDR_W-1:0] addr;
		logic                     ready;
		logic [31:0]              rdata;
		logic [3:0]               p1_o;
		logic [3:0]               p1_oe_n;
		logic                     dtr1_o;
		logic                     dtr1_oe_n;
		logic                     tx_act1;
		logic                     tx_act2;
		logic                     txd2;
		logic                     rts1_n;
		logic                     rts2_pin;
		logic                     dtr2_n;
		logic                     rxd2;
		logic                     t2_clk;
		logic                     t0_clk;
		logic                     t1_gate;
		logic                     t0_gate;
		logic                     msi1;
		logic                     msi2;
	} umlps_state_s;
endpackage
`default_nettype wire

// >>> hw/umlps_top.sv
// modem handshake lines of two serial ports with timer pin sharing
`default_nettype none
`include "umlps_regs.svh"
module umlps_top
	import umlps_pkg::*;
(
	input  wire logic        hclk,
	input  wire logic        hresetn,
	input  wire logic        ce,
	// bus slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic [31:0] hwdata,
	input  wire logic        hready,
	output logic      [31:0] hrdata,
	output logic             hreadyout,
	output logic             hresp,
	// first port pins; cts, dsr, ri, dcd and dtr two-way for general-purpose use
	input  wire logic        cts1_n_i,
	input  wire logic        dsr1_n_i,
	input  wire logic        ri1_n_i,
	input  wire logic        dcd1_n_i,
	input  wire logic        dtr1_n_i,
	output logic             cts1_n_o,
	output logic             dsr1_n_o,
	output logic             ri1_n_o,
	output logic             dcd1_n_o,
	output logic             dtr1_n_o,
	output logic             cts1_oe_n,
	output logic             dsr1_oe_n,
	output logic             ri1_oe_n,
	output logic             dcd1_oe_n,
	output logic             dtr1_oe_n,
	output logic             rts1_n,
	output logic             port1_tx_active,
	// second port pins
	input  wire logic        cts2_n_i,
	input  wire logic        dsr2_n_i,
	input  wire logic        ri2_n_i,
	input  wire logic        dcd2_n_i,
	input  wire logic        rxd2_i,
	output logic             txd2_o,
	output logic             rts2_n,
	output logic             dtr2_n,
	output logic             port2_tx_active,
	// serial engines on the same clock
	input  wire logic        uart1_tx_busy,
	input  wire logic        uart2_tx_busy,
	input  wire logic        uart2_txd,
	output logic             uart2_rxd,
	output logic             port1_msi,
	output logic             port2_msi,
	// timers on the same clock
	input  wire logic        pwm_t0_output,
	input  wire logic        pwm_t1_output,
	output logic             pwm_t2_ext_clock,
	output logic             pwm_t0_ext_clock,
	output logic             pwm_t1_gate_mask,
	output logic             pwm_t0_gate_mask
);

	umlps_state_s q;
	umlps_state_s d;

	// status byte: inverted pins above the change flags
	function automatic logic [7:0] stat_value(input logic [3:0] pins_n,
		input logic [3:0] flags);
		stat_value = {~pins_n, flags};
	endfunction

	// pin pattern of one port as seen after synchronisation
	function automatic logic [3:0] port_pins(
		input logic [`UMLPS_SYNC_W-1:0] v, input logic hi);
		port_pins = hi ? v[`UMLPS_P2_LO +: 4] : v[`UMLPS_P1_LO +: 4];
	endfunction

	logic [31:0] wr_addr_unused;
	logic        take;
	logic        is_rd_clr1;
	logic        is_rd_clr2;
	logic [3:0]  p1_now;
	logic [3:0]  p1_old;
	logic [3:0]  p2_now;
	logic [3:0]  p2_old;
	logic [7:0]  gp_in;
	logic [31:0] rd_val;
	logic        pwm_mode;
	logic        loop1;
	logic        loop2;

	always_comb begin
		d = q;
		wr_addr_unused = haddr;
		take = hsel & hready & htrans[1] == `UMLPS_HTRANS_NSEQ
			& hsize == `UMLPS_HSIZE_WORD;
		is_rd_clr1 = 1'b0;
		is_rd_clr2 = 1'b0;
		rd_val = 32'h0000_0000;

		// two-flop synchronisers; only s2 onward feeds logic
		d.s1 = {dtr1_n_i, rxd2_i, dcd2_n_i, ri2_n_i, dsr2_n_i, cts2_n_i,
			dcd1_n_i, ri1_n_i, dsr1_n_i, cts1_n_i};
		d.s2 = q.s1;
		d.s3 = q.s2;
		p1_now = port_pins(q.s2, 1'b0);
		p1_old = port_pins(q.s3, 1'b0);
		p2_now = port_pins(q.s2, 1'b1);
		p2_old = port_pins(q.s3, 1'b1);

		// general-purpose view of the first port's pins
		gp_in = 8'h00;
		gp_in[`UMLPS_GP_DCD] = q.s2[`UMLPS_P1_LO + 3];
		gp_in[`UMLPS_GP_RI]  = q.s2[`UMLPS_P1_LO + 2];
		gp_in[`UMLPS_GP_DTR] = q.s2[`UMLPS_DTR1_IN];
		gp_in[`UMLPS_GP_DSR] = q.s2[`UMLPS_P1_LO + 1];
		gp_in[`UMLPS_GP_CTS] = q.s2[`UMLPS_P1_LO];

		// read mux, evaluated one cycle after the address phase
		case (q.addr)
			`UMLPS_P1_STAT_OFS: begin
				rd_val = {24'h000000, stat_value(p1_now, q.dlt1)};
				is_rd_clr1 = 1'b1;
			end
			`UMLPS_P1_CTL_OFS: rd_val = {27'h0000000, q.ctl1};
			`UMLPS_P1_IER_OFS: rd_val = {28'h0000000, q.ier1};
			`UMLPS_P2_STAT_OFS: begin
				rd_val = {24'h000000, stat_value(p2_now, q.dlt2)};
				is_rd_clr2 = 1'b1;
			end
			`UMLPS_P2_CTL_OFS: rd_val = {27'h0000000, q.ctl2};
			`UMLPS_P2_IER_OFS: rd_val = {28'h0000000, q.ier2};
			`UMLPS_SBCFG_OFS:  rd_val = {24'h000000, q.sbcfg};
			`UMLPS_GP4_CTL_OFS: rd_val = {8'h00, q.gp_out, q.gp_dir,
				q.gp_sel};
			`UMLPS_GP4_IN_OFS: rd_val = {24'h000000, gp_in};
			default:           rd_val = 32'h0000_0000;
		endcase

		// bus phases: writes finish at once, reads take one wait state
		d.ready = 1'b1;
		case (q.bus)
			UMLPS_BUS_IDLE: begin
			end
			UMLPS_BUS_WRITE: begin
				case (q.addr)
					`UMLPS_P1_CTL_OFS: d.ctl1 = hwdata[`UMLPS_CTL_W-1:0];
					`UMLPS_P1_IER_OFS: d.ier1 = hwdata[`UMLPS_IER_W-1:0];
					`UMLPS_P2_CTL_OFS: d.ctl2 = hwdata[`UMLPS_CTL_W-1:0];
					`UMLPS_P2_IER_OFS: d.ier2 = hwdata[`UMLPS_IER_W-1:0];
					`UMLPS_SBCFG_OFS:  d.sbcfg = hwdata[`UMLPS_CHIP_W-1:0];
					`UMLPS_GP4_CTL_OFS: begin
						d.gp_sel = hwdata[`UMLPS_GP_SEL_LO +: `UMLPS_GP_W];
						d.gp_dir = hwdata[`UMLPS_GP_DIR_LO +: `UMLPS_GP_W];
						d.gp_out = hwdata[`UMLPS_GP_OUT_LO +: `UMLPS_GP_W];
					end
					default: begin
					end
				endcase
			end
			UMLPS_BUS_READ: begin
				if (!q.ready) begin
					d.rdata = rd_val;
				end
			end
			default: begin
			end
		endcase
		// a read in its wait cycle is the only time ready is low
		if (q.bus == UMLPS_BUS_READ && !q.ready) begin
			d.bus = UMLPS_BUS_IDLE;
		end else if (take) begin
			d.addr = wr_addr_unused[`UMLPS_ADDR_W-1:0];
			d.bus = hwrite ? UMLPS_BUS_WRITE : UMLPS_BUS_READ;
			d.ready = hwrite;
		end else begin
			d.bus = UMLPS_BUS_IDLE;
		end
		// the clear happens on the cycle the status word is captured
		if (!(q.bus == UMLPS_BUS_READ && !q.ready)) begin
			is_rd_clr1 = 1'b0;
			is_rd_clr2 = 1'b0;
		end

		// change flags: a fresh rise wins over the read clear
		d.dlt1 = (q.dlt1 & ~{4{is_rd_clr1}}) | (p1_now & ~p1_old);
		d.dlt2 = (q.dlt2 & ~{4{is_rd_clr2}}) | (p2_now & ~p2_old);
		// any edge of any input holds the modem interrupt until read
		d.chg1 = (q.chg1 & ~is_rd_clr1) | (|(p1_now ^ p1_old));
		d.chg2 = (q.chg2 & ~is_rd_clr2) | (|(p2_now ^ p2_old));
		d.msi1 = q.chg1 & q.ier1[`UMLPS_IER_MSI];
		d.msi2 = q.chg2 & q.ier2[`UMLPS_IER_MSI];

		// handshake outputs, held inactive in loopback
		loop1 = q.ctl1[`UMLPS_CTL_LOOP];
		loop2 = q.ctl2[`UMLPS_CTL_LOOP];
		d.rts1_n = ~(q.ctl1[`UMLPS_CTL_RTS] & ~loop1);
		d.dtr2_n = ~(q.ctl2[`UMLPS_CTL_DTR] & ~loop2);

		// first port pins: modem role unless general-purpose selected
		d.p1_oe_n = 4'hf;
		d.p1_o = 4'hf;
		if (q.gp_sel[`UMLPS_GP_CTS]) begin
			d.p1_o[0] = q.gp_out[`UMLPS_GP_CTS];
			d.p1_oe_n[0] = ~q.gp_dir[`UMLPS_GP_CTS];
		end
		if (q.gp_sel[`UMLPS_GP_DSR]) begin
			d.p1_o[1] = q.gp_out[`UMLPS_GP_DSR];
			d.p1_oe_n[1] = ~q.gp_dir[`UMLPS_GP_DSR];
		end
		if (q.gp_sel[`UMLPS_GP_RI]) begin
			d.p1_o[2] = q.gp_out[`UMLPS_GP_RI];
			d.p1_oe_n[2] = ~q.gp_dir[`UMLPS_GP_RI];
		end
		if (q.gp_sel[`UMLPS_GP_DCD]) begin
			d.p1_o[3] = q.gp_out[`UMLPS_GP_DCD];
			d.p1_oe_n[3] = ~q.gp_dir[`UMLPS_GP_DCD];
		end
		if (q.gp_sel[`UMLPS_GP_DTR]) begin
			d.dtr1_o = q.gp_out[`UMLPS_GP_DTR];
			d.dtr1_oe_n = ~q.gp_dir[`UMLPS_GP_DTR];
		end else begin
			d.dtr1_o = ~(q.ctl1[`UMLPS_CTL_DTR] & ~loop1);
			d.dtr1_oe_n = 1'b0;
		end

		// activity indicators follow the transmitters one cycle later, through the state register
		d.tx_act1 = uart1_tx_busy;
		d.tx_act2 = uart2_tx_busy;

		// second port sharing with the timers
		pwm_mode = q.sbcfg[`UMLPS_CHIP_PWM];
		// transmit data passes regardless of clear-to-send
		d.txd2 = pwm_mode ? pwm_t0_output : uart2_txd;
		d.rts2_pin = pwm_mode ? pwm_t1_output
			: ~(q.ctl2[`UMLPS_CTL_RTS] & ~loop2);
		d.rxd2 = q.s2[`UMLPS_RXD2];
		// timer inputs idle low while the pins serve the port
		d.t2_clk = pwm_mode & q.s2[`UMLPS_RXD2];
		d.t0_clk = pwm_mode & q.s2[`UMLPS_P2_LO + 3];
		d.t1_gate = pwm_mode & q.s2[`UMLPS_P2_LO];
		d.t0_gate = pwm_mode & q.s2[`UMLPS_P2_LO + 1];
	end

	// one register for the whole state; ce freezes everything
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			q <= '0;
			q.s1 <= `UMLPS_RST_SYNC;
			q.s2 <= `UMLPS_RST_SYNC;
			q.s3 <= `UMLPS_RST_SYNC;
			q.ctl1 <= `UMLPS_RST_CTL;
			q.ctl2 <= `UMLPS_RST_CTL;
			q.ier1 <= `UMLPS_RST_IER;
			q.ier2 <= `UMLPS_RST_IER;
			q.sbcfg <= `UMLPS_RST_CHIP;
			q.gp_sel <= `UMLPS_RST_GP;
			q.gp_dir <= `UMLPS_RST_GP;
			q.gp_out <= `UMLPS_RST_GP;
			q.bus <= UMLPS_BUS_IDLE;
			q.ready <= 1'b1;
			q.p1_o <= 4'hf;
			q.p1_oe_n <= 4'hf;
			q.dtr1_o <= 1'b1;
			q.rts1_n <= 1'b1;
			q.rts2_pin <= 1'b1;
			q.dtr2_n <= 1'b1;
			q.txd2 <= 1'b1;
			q.rxd2 <= 1'b1;
		end else if (ce) begin
			q <= d;
		end
	end

	// every output except hresp, which is tied to zero, comes straight from the state register
	assign hrdata           = q.rdata;
	assign hreadyout        = q.ready;
	assign hresp            = 1'b0;
	assign cts1_n_o         = q.p1_o[0];
	assign dsr1_n_o         = q.p1_o[1];
	assign ri1_n_o          = q.p1_o[2];
	assign dcd1_n_o         = q.p1_o[3];
	assign dtr1_n_o         = q.dtr1_o;
	assign cts1_oe_n        = q.p1_oe_n[0];
	assign dsr1_oe_n        = q.p1_oe_n[1];
	assign ri1_oe_n         = q.p1_oe_n[2];
	assign dcd1_oe_n        = q.p1_oe_n[3];
	assign dtr1_oe_n        = q.dtr1_oe_n;
	assign rts1_n           = q.rts1_n;
	assign port1_tx_active  = q.tx_act1;
	assign txd2_o           = q.txd2;
	assign rts2_n           = q.rts2_pin;
	assign dtr2_n           = q.dtr2_n;
	assign port2_tx_active  = q.tx_act2;
	assign uart2_rxd        = q.rxd2;
	assign port1_msi        = q.msi1;
	assign port2_msi        = q.msi2;
	assign pwm_t2_ext_clock = q.t2_clk;
	assign pwm_t0_ext_clock = q.t0_clk;
	assign pwm_t1_gate_mask = q.t1_gate;
	assign pwm_t0_gate_mask = q.t0_gate;

endmodule
`default_nettype wire

// >>> dv/umlps_checker.sv
// bus and pin timing assertions for the modem-line block
`default_nettype none
module umlps_checker (
	input wire logic        hclk,
	input wire logic        hresetn,
	input wire logic        ce,
	input wire logic        hsel,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [2:0]  hsize,
	input wire logic        hready,
	input wire logic [31:0] hrdata,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic        cts1_n_i,
	input wire logic        dsr1_n_i,
	input wire logic        ri1_n_i,
	input wire logic        dcd1_n_i,
	input wire logic        rts1_n,
	input wire logic        dtr2_n,
	input wire logic        port1_tx_active,
	input wire logic        uart1_tx_busy,
	input wire logic        txd2_o,
	input wire logic        uart2_txd,
	input wire logic        pwm_t0_output,
	input wire logic        port1_msi
);
	timeunit 1ns;
	timeprecision 1ps;
	logic       take;
	logic [3:0] pin_q;
	logic [5:0] hist_q;
	// a transfer the slave accepts this edge
	assign take = ce & hsel & hready & htrans[1] & (hsize == 3'h2);
	// recent pin changes, long enough to cover the sync delay
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pin_q <= 4'hf;
			hist_q <= 6'h00;
		end else begin
			pin_q <= {cts1_n_i, dsr1_n_i, ri1_n_i, dcd1_n_i};
			hist_q <= {hist_q[4:0],
				pin_q != {cts1_n_i, dsr1_n_i, ri1_n_i, dcd1_n_i}};
		end
	end
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	a_bus_okay: assert property (hresp == 1'b0)
		else $error("response not okay");
	a_read_wait: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
		else $error("read wait state wrong");
	a_write_nowait: assert property (take && hwrite |=> hreadyout)
		else $error("write stalled");
	a_rdata_hold: assert property (!$rose(hreadyout) |-> $stable(hrdata))
		else $error("read data moved");
	a_tx_active: assert property (
		port1_tx_active == $past(uart1_tx_busy))
		else $error("activity output wrong");
	a_txd2_source: assert property (
		txd2_o == $past(uart2_txd) || txd2_o == $past(pwm_t0_output))
		else $error("transmit pin from unknown source");
	a_reset_idle: assert property (
		$rose(hresetn) |-> rts1_n && dtr2_n)
		else $error("handshake outputs active after reset");
	a_msi_cause: assert property ($rose(port1_msi) |-> |hist_q)
		else $error("interrupt without pin change");
endmodule
`default_nettype wire

// >>> dv/umlps_modem.sv
// handshake side of an attached modem, one per port
`default_nettype none
module umlps_modem (
	input  wire logic [3:0] want,
	output logic      [3:0] pin_n
);
	timeunit 1ns;
	timeprecision 1ps;
	// order cts, dsr, ri, dcd; an asserted condition is a low pin
	assign pin_n = ~want;
endmodule
`default_nettype wire

// >>> dv/uart_modem_lines_pwm_share_test.sv
// self-checking bench of the modem-line block
`default_nettype none
`include "umlps_regs.svh"
module uart_modem_lines_pwm_share_test;
	timeunit 1ns;
	timeprecision 1ps;
	logic hclk, hresetn, hwrite, hrdy, hresp;
	logic [1:0] htrans;
	logic [31:0] haddr, hwdata, hrdata;
	logic [3:0] m [2];
	logic [3:0] p1n, p2n, o1, oe1, pin1;
	logic cts_o, dsr_o, ri_o, dcd_o, cts_e, dsr_e, ri_e, dcd_e;
	logic dtr_o, dtr_e, rts1_n, act1, txd2_o, rts2_n, dtr2_n, msi1;
	logic b1, b2, txd2, rxd2, pw0, pw1, t2c, t0c, t1g, t0g;
	logic act2, urx, msi2;
	int n_mismatch, checked;
	// first port pins: block drives when its enable is low, else modem
	assign o1 = {dcd_o, ri_o, dsr_o, cts_o};
	assign oe1 = {dcd_e, ri_e, dsr_e, cts_e};
	assign pin1 = (oe1 & p1n) | (~oe1 & o1);
	umlps_modem u_modem1 (.want(m[0]), .pin_n(p1n));
	umlps_modem u_modem2 (.want(m[1]), .pin_n(p2n));
	umlps_top u_umlps_top (.hclk, .hresetn, .ce(1'b1), .hsel(1'b1),
		.haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hrdy),
		.hrdata, .hreadyout(hrdy), .hresp, .cts1_n_i(pin1[0]),
		.dsr1_n_i(pin1[1]), .ri1_n_i(pin1[2]), .dcd1_n_i(pin1[3]),
		.dtr1_n_i(dtr_e | dtr_o), .cts1_n_o(cts_o), .dsr1_n_o(dsr_o),
		.ri1_n_o(ri_o), .dcd1_n_o(dcd_o), .dtr1_n_o(dtr_o),
		.cts1_oe_n(cts_e), .dsr1_oe_n(dsr_e), .ri1_oe_n(ri_e),
		.dcd1_oe_n(dcd_e), .dtr1_oe_n(dtr_e), .rts1_n,
		.port1_tx_active(act1), .cts2_n_i(p2n[0]), .dsr2_n_i(p2n[1]),
		.ri2_n_i(p2n[2]), .dcd2_n_i(p2n[3]), .rxd2_i(rxd2), .txd2_o,
		.rts2_n, .dtr2_n, .port2_tx_active(act2), .uart1_tx_busy(b1),
		.uart2_tx_busy(b2), .uart2_txd(txd2), .uart2_rxd(urx),
		.port1_msi(msi1), .port2_msi(msi2), .pwm_t0_output(pw0),
		.pwm_t1_output(pw1), .pwm_t2_ext_clock(t2c),
		.pwm_t0_ext_clock(t0c), .pwm_t1_gate_mask(t1g),
		.pwm_t0_gate_mask(t0g));
	task automatic end_sim;
		$display("comparisons %0d mismatches %0d", checked, n_mismatch);
		if (n_mismatch == 0 && checked > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("Error at %0t: got %h want %h", $time, got, exp);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge hclk);
	endtask
	// one single word transfer; waits on hready, never on a count
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] r);
		haddr <= {24'h0, a};
		hwrite <= w;
		htrans <= 2'h2;
		@(posedge hclk);
		while (hrdy !== 1'b1) @(posedge hclk);
		htrans <= 2'h0;
		hwdata <= d;
		@(posedge hclk);
		while (hrdy !== 1'b1) @(posedge hclk);
		r = hrdata;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		bus(1'b1, a, d, r);
	endtask
	task automatic rc(input logic [7:0] a, input logic [31:0] k,
		input logic [31:0] e);
		logic [31:0] r;
		bus(1'b0, a, 32'h0, r);
		chk(r & k, e);
	endtask
	task automatic t_reset;
		chk({rts1_n, dtr_o, rts2_n, dtr2_n, act1}, 5'h1e);
		rc(`UMLPS_P1_STAT_OFS, 32'hffffffff, 32'h0);
		wr(8'h24, 32'h5a);
		rc(8'h24, 32'hffffffff, 32'h0);
		$display("reset test done");
	endtask
	task automatic t_status(input int p, input logic [7:0] a);
		for (int k = 0; k < 4; k++) begin
			m[p][k] <= 1'b1;
			cyc(6);
			rc(a, 32'hff, 32'h10 << k);
			m[p][k] <= 1'b0;
			cyc(6);
			rc(a, 32'hff, 32'h1 << k);
			rc(a, 32'hff, 32'h0);
		end
		$display("status test done port %0d", p + 1);
	endtask
	task automatic t_irq;
		wr(`UMLPS_P1_IER_OFS, 32'h8);
		m[0][2] <= 1'b1;
		cyc(6);
		chk(msi1, 1'b1);
		rc(`UMLPS_P1_STAT_OFS, 32'h40, 32'h40);
		cyc(2);
		chk(msi1, 1'b0);
		wr(`UMLPS_P1_IER_OFS, 32'h0);
		m[0][2] <= 1'b0;
		cyc(6);
		chk(msi1, 1'b0);
		rc(`UMLPS_P1_STAT_OFS, 32'hff, 32'h4);
		$display("interrupt test done");
	endtask
	task automatic t_out;
		wr(`UMLPS_P1_CTL_OFS, 32'h1);
		cyc(2);
		chk({rts1_n, dtr_o}, 2'b10);
		wr(`UMLPS_P1_CTL_OFS, 32'h2);
		cyc(2);
		chk({rts1_n, dtr_o}, 2'b01);
		wr(`UMLPS_P1_CTL_OFS, 32'h13);
		wr(`UMLPS_P2_CTL_OFS, 32'h3);
		cyc(2);
		chk({rts1_n, dtr_o, rts2_n, dtr2_n}, 4'hc);
		wr(`UMLPS_P2_CTL_OFS, 32'h13);
		cyc(2);
		chk({rts2_n, dtr2_n}, 2'b11);
		wr(`UMLPS_P1_CTL_OFS, 32'h0);
		wr(`UMLPS_P2_CTL_OFS, 32'h0);
		$display("output test done");
	endtask
	task automatic t_tx;
		b1 <= 1'b1;
		b2 <= 1'b1;
		txd2 <= 1'b0;
		cyc(2);
		chk({act1, act2, txd2_o}, 3'b110);
		b1 <= 1'b0;
		b2 <= 1'b0;
		txd2 <= 1'b1;
		cyc(2);
		chk({act1, act2, txd2_o}, 3'b001);
		$display("transmit test done");
	endtask
	task automatic t_pwm;
		wr(`UMLPS_SBCFG_OFS, 32'h4);
		{pw0, pw1, rxd2} <= 3'b000;
		m[1] <= 4'b0001;
		cyc(6);
		chk({txd2_o, rts2_n, t2c, t0c, t1g, t0g, urx}, 7'h0a);
		{pw0, pw1, rxd2} <= 3'b111;
		m[1] <= 4'b1010;
		cyc(6);
		chk({txd2_o, rts2_n, t2c, t0c, t1g, t0g, urx}, 7'h75);
		wr(`UMLPS_P2_IER_OFS, 32'h8);
		wr(`UMLPS_SBCFG_OFS, 32'h0);
		m[1] <= 4'b0000;
		pw0 <= 1'b0;
		cyc(6);
		chk({txd2_o, t2c, t0c, t1g, t0g}, 5'h10);
		chk(msi2, 1'b1);
		// cts rose in the second step, dsr and dcd in the third
		rc(`UMLPS_P2_STAT_OFS, 32'hff, 32'h0b);
		cyc(2);
		chk(msi2, 1'b0);
		wr(`UMLPS_P2_IER_OFS, 32'h0);
		$display("timer pin test done");
	endtask
	task automatic t_gp4;
		m[0] <= 4'b0001;
		cyc(6);
		rc(`UMLPS_GP4_IN_OFS, 32'he9, 32'h69);
		wr(`UMLPS_GP4_CTL_OFS, 32'ha0a0);
		cyc(6);
		chk({dtr_e, dtr_o, cts_e, cts_o}, 4'h0);
		rc(`UMLPS_GP4_IN_OFS, 32'h20, 32'h0);
		wr(`UMLPS_GP4_CTL_OFS, 32'h0);
		m[0] <= 4'b0000;
		cyc(6);
		rc(`UMLPS_P1_STAT_OFS, 32'hff, 32'h1);
		$display("general purpose test done");
	endtask
	// clock: 50 ns period
	initial begin
		hclk = 1'b0;
		forever #25 hclk = ~hclk;
	end
	// watchdog, far beyond the few hundred cycles the tests need
	initial begin
		repeat (20000) @(posedge hclk);
		n_mismatch++;
		$display("Error at %0t: timeout", $time);
		end_sim();
	end
	initial begin
		n_mismatch = 0;
		checked = 0;
		hresetn = 1'b0;
		{hwrite, htrans, haddr, hwdata} = '0;
		m = '{4'h0, 4'h0};
		{b1, b2, pw0, pw1} = 4'h0;
		{txd2, rxd2} = 2'b11;
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		t_reset();
		t_status(0, `UMLPS_P1_STAT_OFS);
		t_status(1, `UMLPS_P2_STAT_OFS);
		t_irq();
		t_out();
		t_tx();
		t_pwm();
		t_gp4();
		end_sim();
	end
endmodule
bind umlps_top umlps_checker u_umlps_checker (.hclk, .hresetn, .ce,
	.hsel, .htrans, .hwrite, .hsize, .hready, .hrdata, .hreadyout,
	.hresp, .cts1_n_i, .dsr1_n_i, .ri1_n_i, .dcd1_n_i, .rts1_n,
	.dtr2_n, .port1_tx_active, .uart1_tx_busy, .txd2_o, .uart2_txd,
	.pwm_t0_output, .port1_msi);
`default_nettype wire
